//--- rtl/afpo_pkg.sv
// constants and types of the pixel output port of the analogue front end
//
// Function
// R1 - controller runs master clock at N times pixel rate, N 12/8/6/4
// R2 - master clock divided by N forms N-phase timing; clocks all logic
// R3 - sample sync pin bidirectional, input after reset, configurable to output
// R4 - input direction: sample instant and phase counter align to sync pulse
// R5 - output direction: device pulses sync pin at its own sample instant
// R6 - reset clamp applied while clamp select high; tied high clamps each pixel
// R7 - reset clamp and double sampling each selectable or bypassable
// R8 - three channel results multiplexed in turn into one 12-bit converter
// R9 - operating mode, sampling scheme and power down set by control values
// R10 - converted data MSB on bus line 11, LSB on line 0
// R11 - enable low: device drives signal data on bus lines 4 to 11
// R12 - enable high: lines 4 to 11 released, write data accepted from them
// R13 - bus modes: high impedance, 12-bit, 8-bit muxed, readback, one more
// R14 - full-width mode shows whole 12-bit sample at once
// R15 - bytewide mode: 8-bit part then 4-bit part on upper lanes
// R16 - readback mode drives register byte onto lines 11 down to 4
// R17 - override pin level at reset selects device function out of reset
// R18 - bytewide: upper eight first, then low four left-aligned, within one pixel
// R19 - one new sample every N cycles, timed from the sample instant
package afpo_pkg;

   typedef enum logic [2:0]
   {
      AFPO_BUS_HIZ      = 3'b000,
      AFPO_BUS_FULL     = 3'b001,
      AFPO_BUS_BYTE     = 3'b010,
      AFPO_BUS_READBACK = 3'b011,
      AFPO_BUS_TEST     = 3'b100
   } afpo_bus_mode_t;

   localparam int            AFPO_DATA_W     = 12;
   localparam int            AFPO_CHANNELS   = 3;
   localparam int            AFPO_PIN_W      = 12;
   // stable pin bundle: {sync, enable_n, clamp_sel, override, bus[11:4]}
   localparam int            AFPO_PIN_SYNC   = 11;
   localparam int            AFPO_PIN_OEN    = 10;
   localparam int            AFPO_PIN_RLC    = 9;
   localparam int            AFPO_PIN_OVR    = 8;
   localparam logic [11:0]   AFPO_PIN_RST    = 12'h400;
   localparam logic [3:0]    AFPO_N_SEL0     = 4'hC;
   localparam logic [3:0]    AFPO_N_SEL1     = 4'h8;
   localparam logic [3:0]    AFPO_N_SEL2     = 4'h6;
   localparam logic [3:0]    AFPO_N_SEL3     = 4'h4;
   localparam logic [3:0]    AFPO_PHASE_RST  = 4'h0;
   localparam logic [3:0]    AFPO_SAMPLE_PH  = 4'h0;
   localparam logic [1:0]    AFPO_CHAN_RST   = 2'h0;
   localparam logic [1:0]    AFPO_CHAN_LAST  = 2'h2;
   localparam logic [11:0]   AFPO_BUS_RST    = 12'h000;
   localparam logic [11:0]   AFPO_TEST_WORD  = 12'hA5A;

   // N for a divider select code
   function automatic logic [3:0] afpo_div_n(input logic [1:0] sel);
      logic [3:0] n;
      n = AFPO_N_SEL0;
      case (sel)
         2'h0:    n = AFPO_N_SEL0;
         2'h1:    n = AFPO_N_SEL1;
         2'h2:    n = AFPO_N_SEL2;
         default: n = AFPO_N_SEL3;
      endcase
      return n;
   endfunction

endpackage

//--- rtl/afpo_buf2.sv
// two-entry buffer with valid and ready on both sides
module afpo_buf2
   import afpo_pkg::*;
#(
   parameter int WIDTH = 12
)
(
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);

   logic [WIDTH-1:0] mem [2];
   logic             wr_ptr;
   logic             rd_ptr;
   logic [1:0]       count;

   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge ref_clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'h0;
      end
      else
      begin
         wr_ptr <= wr_ptr ^ push;
         rd_ptr <= rd_ptr ^ pop;
         count  <= 2'(count + {1'b0, push} - {1'b0, pop});
      end
   end

endmodule

//--- rtl/afpo_port.sv
// pixel output port: clock divider, sample sync, channel mux and shared bus
module afpo_port
   import afpo_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [1:0]  cfg_div_sel,
   input  wire logic        cfg_sync_output,
   input  wire logic [2:0]  cfg_bus_mode,
   input  wire logic        cfg_clamp_enable,
   input  wire logic        cfg_cds_enable,
   input  wire logic        cfg_power_down,
   input  wire logic [7:0]  readback_data,
   input  wire logic [11:0] chan0_data,
   input  wire logic [11:0] chan1_data,
   input  wire logic [11:0] chan2_data,
   input  wire logic        sample_sync_pulse_in,
   output logic             sample_sync_pulse_out,
   output logic             sample_sync_pulse_oe,
   input  wire logic        reset_clamp_select,
   input  wire logic        bus_drive_enable_n,
   input  wire logic        reset_function_override,
   input  wire logic [11:4] pixel_bus_in,
   output logic [11:0]      pixel_bus_out,
   output logic             pixel_bus_hi_oe,
   output logic             pixel_bus_lo_oe,
   output logic [7:0]       reg_write_data,
   output logic             reg_write_strobe,
   output logic             clamp_active,
   output logic             cds_active,
   output logic             sample_instant,
   output logic [1:0]       conv_channel,
   output logic             function_select,
   output logic             sample_overrun
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [AFPO_PIN_W-1:0] pin_s1;
   logic [AFPO_PIN_W-1:0] pin_s2;
   logic [AFPO_PIN_W-1:0] pin_s3;
   logic [AFPO_PIN_W-1:0] pin;

   wire [AFPO_PIN_W-1:0] pin_raw = {sample_sync_pulse_in, bus_drive_enable_n,
                                    reset_clamp_select, reset_function_override,
                                    pixel_bus_in};
   // a bit changes only once second and third stage agree
   wire [AFPO_PIN_W-1:0] next_pin = (pin_s2 & pin_s3) | (pin & (pin_s2 | pin_s3));

   // stages run through reset so the strap sees the settled pin level
   always_ff @(posedge ref_clk)
   begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (rst)
         pin <= AFPO_PIN_RST;
      else
         pin <= next_pin;
   end

   wire sync_pin  = pin[AFPO_PIN_SYNC];
   wire oe_n_pin  = pin[AFPO_PIN_OEN];
   wire rlc_pin   = pin[AFPO_PIN_RLC];
   wire [7:0] bus_pin = pin[7:0];

   // ****************************************
   // override strap, caught after reset release
   // ****************************************
   logic strap_done;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         strap_done      <= 1'b0;
         function_select <= 1'b0;
      end
      else if (!strap_done)
      begin
         strap_done      <= 1'b1;
         function_select <= next_pin[AFPO_PIN_OVR];   // [R17]
      end
   end

   // ****************************************
   // N-phase divider and sample instant
   // ****************************************
   logic [3:0] phase;
   logic       sync_prev;

   wire [3:0] div_n      = afpo_div_n(cfg_div_sel);   // [R1]
   wire       sync_rise  = sync_pin && !sync_prev;
   wire       ext_align  = !cfg_sync_output && sync_rise;
   wire       phase_wrap = (phase >= 4'(div_n - 4'h1));
   wire [3:0] half_n     = {1'b0, div_n[3:1]};
   wire       at_sample  = (phase == AFPO_SAMPLE_PH) && !cfg_power_down;
   wire       at_half    = (phase == half_n) && !cfg_power_down;
   wire [3:0] next_phase = (ext_align || phase_wrap) ? AFPO_PHASE_RST
                         : 4'(phase + 4'h1);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         phase     <= AFPO_PHASE_RST;
         sync_prev <= 1'b0;
      end
      else
      begin
         // first edge after reset takes the pin itself: no false rise
         sync_prev <= strap_done ? sync_pin : next_pin[AFPO_PIN_SYNC];
         if (!cfg_power_down)
            phase <= next_phase;   // [R2] [R4] [R9]
      end
   end

   // ****************************************
   // sync pin direction and output pulse
   // ****************************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sample_sync_pulse_oe  <= 1'b0;
         sample_sync_pulse_out <= 1'b0;
         sample_instant        <= 1'b0;
      end
      else
      begin
         sample_sync_pulse_oe  <= cfg_sync_output;                // [R3]
         sample_sync_pulse_out <= cfg_sync_output && at_sample;   // [R5]
         sample_instant        <= at_sample;
      end
   end

   // ****************************************
   // clamp and double sampling controls
   // ****************************************
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         clamp_active <= 1'b0;
         cds_active   <= 1'b0;
      end
      else
      begin
         clamp_active <= cfg_clamp_enable && rlc_pin && at_sample;   // [R6] [R7]
         cds_active   <= cfg_cds_enable && !cfg_power_down;          // [R7]
      end
   end

   // ****************************************
   // channel multiplexer into the converter
   // ****************************************
   logic [1:0]  chan;
   logic [11:0] word_out;
   logic        word_valid;
   logic        buf_in_ready;
   logic        buf_out_valid;

   wire [11:0] chan_word = (chan == 2'h0) ? chan0_data
                         : (chan == 2'h1) ? chan1_data : chan2_data;
   wire        conv_push = at_sample && buf_in_ready;
   wire [1:0]  next_chan = (chan == AFPO_CHAN_LAST) ? AFPO_CHAN_RST : 2'(chan + 2'h1);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         chan           <= AFPO_CHAN_RST;
         conv_channel   <= AFPO_CHAN_RST;
         sample_overrun <= 1'b0;
      end
      else
      begin
         if (conv_push)
            chan <= next_chan;   // [R8] [R19]
         conv_channel   <= chan;
         sample_overrun <= at_sample && !buf_in_ready;
      end
   end

   // ****************************************
   // bus drain side
   // ****************************************
   wire drive     = !oe_n_pin;
   wire mode_full = (cfg_bus_mode == AFPO_BUS_FULL);
   wire mode_byte = (cfg_bus_mode == AFPO_BUS_BYTE);
   wire mode_rb   = (cfg_bus_mode == AFPO_BUS_READBACK);
   wire mode_test = (cfg_bus_mode == AFPO_BUS_TEST);
   wire pop       = drive && (mode_full || mode_byte) && at_sample && buf_out_valid;

   afpo_buf2 #(
      .WIDTH (AFPO_DATA_W)
   ) u_buf (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_data   (chan_word),
      .in_valid  (at_sample),
      .in_ready  (buf_in_ready),
      .out_data  (word_out),
      .out_valid (buf_out_valid),
      .out_ready (pop)
   );

   assign word_valid = buf_out_valid;

   logic [3:0] held_low;

   wire [11:0] byte_hi  = {word_out[11:4], 4'h0};
   wire [11:0] byte_lo  = {held_low, 8'h00};
   wire [11:0] rb_word  = {readback_data, 4'h0};
   wire [11:0] next_bus = (!drive)               ? AFPO_BUS_RST
                        : (mode_full && pop)     ? word_out      // [R10] [R14]
                        : (mode_byte && pop)     ? byte_hi       // [R15] [R18]
                        : (mode_byte && at_half) ? byte_lo       // [R18]
                        : mode_rb                ? rb_word       // [R16]
                        : mode_test              ? AFPO_TEST_WORD
                        : pixel_bus_out;
   wire        next_hi_oe = drive && (mode_full || mode_byte || mode_rb || mode_test);
   wire        next_lo_oe = drive && (mode_full || mode_test);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pixel_bus_out   <= AFPO_BUS_RST;
         pixel_bus_hi_oe <= 1'b0;
         pixel_bus_lo_oe <= 1'b0;
         held_low        <= 4'h0;
      end
      else
      begin
         pixel_bus_out   <= next_bus;
         pixel_bus_hi_oe <= next_hi_oe;   // [R11] [R12] [R13]
         pixel_bus_lo_oe <= next_lo_oe;
         if (pop)
            held_low <= word_out[3:0];
      end
   end

   // ****************************************
   // register write data from the bus
   // ****************************************
   logic oe_n_prev;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         oe_n_prev        <= 1'b1;
         reg_write_data   <= 8'h00;
         reg_write_strobe <= 1'b0;
      end
      else
      begin
         oe_n_prev        <= strap_done ? oe_n_pin : next_pin[AFPO_PIN_OEN];
         reg_write_strobe <= oe_n_prev && !oe_n_pin;   // [R12]
         if (oe_n_pin)
            reg_write_data <= bus_pin;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   property p_phase_range;
      @(posedge ref_clk) disable iff (rst)
         $stable(cfg_div_sel) && !$past(cfg_power_down) |-> phase < div_n;
   endproperty
   a_phase_range: assert property (p_phase_range) else $error("phase beyond divider"); // [R2]

   property p_sync_dir;
      @(posedge ref_clk) rst |=> !sample_sync_pulse_oe;
   endproperty
   a_sync_dir: assert property (p_sync_dir) else $error("sync pin not input at reset"); // [R3]

   property p_align;
      @(posedge ref_clk) disable iff (rst) ext_align && !cfg_power_down |=> phase == 4'h0;
   endproperty
   a_align: assert property (p_align) else $error("phase not aligned to sync"); // [R4]

   property p_sync_out;
      @(posedge ref_clk) disable iff (rst)
         cfg_sync_output && at_sample |=> sample_sync_pulse_out ##1 !sample_sync_pulse_out;
   endproperty
   a_sync_out: assert property (p_sync_out) else $error("sync output pulse wrong"); // [R5]

   property p_clamp;
      @(posedge ref_clk) disable iff (rst)
         clamp_active |-> $past(rlc_pin) && $past(cfg_clamp_enable);
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp without select"); // [R6]

   property p_release;
      @(posedge ref_clk) disable iff (rst) oe_n_pin |=> !pixel_bus_hi_oe && !pixel_bus_lo_oe;
   endproperty
   a_release: assert property (p_release) else $error("bus driven while released"); // [R12]

   property p_drive;
      @(posedge ref_clk) disable iff (rst) !oe_n_pin && mode_full |=> pixel_bus_hi_oe;
   endproperty
   a_drive: assert property (p_drive) else $error("bus not driven"); // [R11]

   property p_full_word;
      @(posedge ref_clk) disable iff (rst) mode_full && pop |=> pixel_bus_out == $past(word_out);
   endproperty
   a_full_word: assert property (p_full_word) else $error("full word wrong"); // [R14]

   property p_readback;
      @(posedge ref_clk) disable iff (rst)
         drive && mode_rb |=> pixel_bus_out[11:4] == $past(readback_data);
   endproperty
   a_readback: assert property (p_readback) else $error("readback byte wrong"); // [R16]

   property p_byte_low;
      @(posedge ref_clk) disable iff (rst)
         drive && mode_byte && at_half && !pop |=> pixel_bus_out == {held_low, 8'h00};
   endproperty
   a_byte_low: assert property (p_byte_low) else $error("low nibble wrong"); // [R18]

   property p_rate;
      @(posedge ref_clk) disable iff (rst) conv_push |-> phase == AFPO_SAMPLE_PH;
   endproperty
   a_rate: assert property (p_rate) else $error("sample off the instant"); // [R19]

   property p_chan;
      @(posedge ref_clk) disable iff (rst) conv_push |=> chan == $past(next_chan);
   endproperty
   a_chan: assert property (p_chan) else $error("channel order wrong"); // [R8]

   property p_strap;
      @(posedge ref_clk) disable iff (rst) strap_done |=> $stable(function_select);
   endproperty
   a_strap: assert property (p_strap) else $error("strap changed"); // [R17]

   c_full: cover property (@(posedge ref_clk) disable iff (rst) mode_full && pop);
   c_byte: cover property (@(posedge ref_clk) disable iff (rst) mode_byte && pop ##[1:8] at_half);
   c_align: cover property (@(posedge ref_clk) disable iff (rst) ext_align);
   c_overrun: cover property (@(posedge ref_clk) disable iff (rst) sample_overrun);

endmodule

//--- tb/afpo_ctrl_model.sv
// scanner controller model: sync pin, write data and bus enable
module afpo_ctrl_model
(
   input  wire logic       ref_clk,
   input  wire logic       dev_sync_out,
   input  wire logic       dev_sync_oe,
   input  wire logic [7:0] dev_bus,
   input  wire logic       dev_bus_oe,
   output logic            sync_pin,
   output logic            enable_n,
   output logic [7:0]      bus_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       sync_drv = 1'b0;
   logic       wr_on    = 1'b0;
   logic [7:0] wr_byte  = 8'h00;
   logic [7:0] last_bus = 8'h00;

   initial enable_n = 1'b0;

   // pin levels from both parties' enables; released bus toggles
   assign sync_pin = dev_sync_oe ? dev_sync_out : sync_drv;
   assign bus_pin  = dev_bus_oe ? dev_bus : (wr_on ? wr_byte : ~last_bus);

   always @(posedge ref_clk) last_bus <= bus_pin;

   task automatic pulse_sync();
      @(posedge ref_clk);
      sync_drv <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sync_drv <= 1'b0;
   endtask

   task automatic start_write(input logic [7:0] b);
      @(posedge ref_clk);
      enable_n <= 1'b1;
      wr_on    <= 1'b1;
      wr_byte  <= b;
   endtask

   task automatic end_write();
      @(posedge ref_clk);
      enable_n <= 1'b0;
      wr_on    <= 1'b0;
   endtask
endmodule

//--- tb/afe_pixel_output_port_tb.sv
// self-checking testbench of the pixel output port
module afe_pixel_output_port_tb;
   import afpo_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic [1:0]  cfg_div_sel = 2'h3;
   logic        cfg_sync_output = 1'b0;
   logic [2:0]  cfg_bus_mode = 3'h1;
   logic        cfg_clamp_enable = 1'b0;
   logic        cfg_cds_enable = 1'b0;
   logic        cfg_power_down = 1'b0;
   logic [7:0]  readback_data = 8'h5A;
   logic [11:0] chan_data = 12'h9C3;
   logic        reset_clamp_select = 1'b0;
   logic        override_pin = 1'b0;
   logic        sync_pin, enable_n, sync_out, sync_oe, hi_oe, lo_oe;
   logic        reg_write_strobe, clamp_active, cds_active, sample_instant;
   logic        function_select, sample_overrun;
   logic [7:0]  bus_pin, reg_write_data;
   logic [11:0] bus_out;
   logic [1:0]  conv_channel;
   int          err_count = 0;
   int          n_checks = 0;
   logic [11:0] n_tab [4] = '{12'h00C, 12'h008, 12'h006, 12'h004};

   afpo_port dut (.ref_clk(ref_clk), .rst(rst), .cfg_div_sel(cfg_div_sel),
      .cfg_sync_output(cfg_sync_output), .cfg_bus_mode(cfg_bus_mode),
      .cfg_clamp_enable(cfg_clamp_enable), .cfg_cds_enable(cfg_cds_enable),
      .cfg_power_down(cfg_power_down), .readback_data(readback_data),
      .chan0_data(chan_data), .chan1_data(chan_data), .chan2_data(chan_data),
      .sample_sync_pulse_in(sync_pin), .sample_sync_pulse_out(sync_out),
      .sample_sync_pulse_oe(sync_oe), .reset_clamp_select(reset_clamp_select),
      .bus_drive_enable_n(enable_n), .reset_function_override(override_pin),
      .pixel_bus_in(bus_pin), .pixel_bus_out(bus_out), .pixel_bus_hi_oe(hi_oe),
      .pixel_bus_lo_oe(lo_oe), .reg_write_data(reg_write_data),
      .reg_write_strobe(reg_write_strobe), .clamp_active(clamp_active),
      .cds_active(cds_active), .sample_instant(sample_instant),
      .conv_channel(conv_channel), .function_select(function_select),
      .sample_overrun(sample_overrun));

   afpo_ctrl_model u_ctrl (.ref_clk(ref_clk), .dev_sync_out(sync_out),
      .dev_sync_oe(sync_oe), .dev_bus(bus_out[11:4]), .dev_bus_oe(hi_oe),
      .sync_pin(sync_pin), .enable_n(enable_n), .bus_pin(bus_pin));

   always #12.5 ref_clk = ~ref_clk;

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // cycles until the next pulse: 0 sample instant, 1 sync out
   task automatic wait_on(input int which, output logic [11:0] gap);
      gap = 12'h000;
      do
      begin
         @(negedge ref_clk);
         gap++;
      end while (((which == 0) ? sample_instant : sync_out) !== 1'b1 && gap < 12'h0C8);
   endtask

   // pulse seen within n cycles: 0 clamp, 1 strobe, 2 overrun, 3 instant
   task automatic seen_pulse(input int which, input int n, output logic s);
      logic [3:0] v;
      s = 1'b0;
      repeat (n)
      begin
         @(negedge ref_clk);
         v = {sample_instant, sample_overrun, reg_write_strobe, clamp_active};
         if (v[which] === 1'b1) s = 1'b1;
      end
   endtask

   task automatic set_mode(input logic [2:0] m, input logic [1:0] d);
      @(posedge ref_clk);
      cfg_bus_mode <= m;
      cfg_div_sel  <= d;
      idle(40);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_divider();
      logic [11:0] g;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge ref_clk);
         cfg_div_sel <= 2'(i);
         repeat (3) wait_on(0, g);
         wait_on(0, g);
         check(g, n_tab[i]);
      end
   endtask

   task automatic t_full();
      logic [1:0]  c;
      logic [11:0] g;
      set_mode(3'h1, 2'h3);
      check(bus_out, 12'h9C3);
      check({10'h0, hi_oe, lo_oe}, 12'h003);
      wait_on(0, g);
      c = conv_channel;
      repeat (3)
      begin
         wait_on(0, g);
         check({10'h0, conv_channel}, {10'h0, (c == 2'h2) ? 2'h0 : c + 2'h1});
         c = conv_channel;
      end
   endtask

   task automatic t_modes();
      logic h, l;
      set_mode(3'h2, 2'h1);
      h = 1'b0;
      l = 1'b0;
      repeat (8)
      begin
         @(negedge ref_clk);
         if (bus_out === 12'h9C0) h = 1'b1;
         if (bus_out === 12'h300) l = 1'b1;
      end
      check({10'h0, h, l}, 12'h003);
      check({11'h0, lo_oe}, 12'h000);
      set_mode(3'h3, 2'h3);
      check({4'h0, bus_out[11:4]}, 12'h05A);
      check({11'h0, hi_oe}, 12'h001);
      set_mode(3'h4, 2'h3);
      check(bus_out, 12'hA5A);
      set_mode(3'h0, 2'h3);
      check({10'h0, hi_oe, lo_oe}, 12'h000);
   endtask

   task automatic t_write();
      logic s;
      set_mode(3'h1, 2'h3);
      u_ctrl.start_write(8'h3C);
      idle(12);
      check({11'h0, hi_oe}, 12'h000);
      check({4'h0, reg_write_data}, 12'h03C);
      u_ctrl.end_write();
      seen_pulse(1, 10, s);
      check({11'h0, s}, 12'h001);
      check({4'h0, reg_write_data}, 12'h03C);
      u_ctrl.start_write(8'h00);
      seen_pulse(2, 40, s);
      check({11'h0, s}, 12'h001);
      u_ctrl.end_write();
      idle(30);
   endtask

   task automatic t_sync();
      logic [11:0] d1, d2;
      @(posedge ref_clk);
      cfg_sync_output <= 1'b1;
      idle(10);
      check({11'h0, sync_oe}, 12'h001);
      wait_on(1, d1);
      wait_on(1, d1);
      check(d1, 12'h004);
      @(posedge ref_clk);
      cfg_sync_output <= 1'b0;
      set_mode(3'h1, 2'h0);
      u_ctrl.pulse_sync();
      wait_on(0, d1);
      // second pulse lands well away from the free-running instant
      idle(1);
      u_ctrl.pulse_sync();
      wait_on(0, d2);
      check(d2, 12'h005);
   endtask

   task automatic t_clamp_power();
      logic s;
      @(posedge ref_clk);
      cfg_clamp_enable   <= 1'b1;
      reset_clamp_select <= 1'b1;
      cfg_cds_enable     <= 1'b1;
      seen_pulse(0, 40, s);
      check({11'h0, s}, 12'h001);
      check({11'h0, cds_active}, 12'h001);
      @(posedge ref_clk);
      cfg_clamp_enable <= 1'b0;
      cfg_cds_enable   <= 1'b0;
      idle(10);
      seen_pulse(0, 40, s);
      check({10'h0, s, cds_active}, 12'h000);
      @(posedge ref_clk);
      cfg_power_down <= 1'b1;
      idle(10);
      seen_pulse(3, 40, s);
      check({11'h0, s}, 12'h000);
      @(posedge ref_clk);
      cfg_power_down <= 1'b0;
   endtask

   task automatic t_reset();
      logic s;
      @(posedge ref_clk);
      rst          <= 1'b1;
      override_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      idle(2);
      check({9'h0, sync_oe, hi_oe, function_select}, 12'h001);
      seen_pulse(1, 20, s);
      check({11'h0, s}, 12'h000);
   endtask

   // ****************************************
   // run control
   // ****************************************
   task automatic summarize();
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      idle(10);
      check({10'h0, sync_oe, function_select}, 12'h000);
      t_divider();
      t_full();
      t_modes();
      t_write();
      t_sync();
      t_clamp_power();
      t_reset();
      summarize();
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      summarize();
   end
endmodule
